/* File: design/alarm_defines.svh */
// Register offsets, field positions and reset values of the alarm status and mask logic
//Contract
//- Status bit 4 follows remote temperature above remote high setpoint; raises alert.
//- Status bit 3 follows remote temperature below remote low setpoint; raises alert.
//- Status bit 2 flags open or shorted diode; never raises an alert.
//- Status bit 1 follows remote temperature above critical limit; raises alert.
//- Status bit 0 flags tach count above limit, meaning fan too slow.
//- Tach alarm gives no external alert while the pin is a tach input; host polls status instead.
//- Status bit 5 reads zero; status register is read-only.
//- Mask bits 7, 5 and 2 always read one.
//- Mask bit 6, reset zero, gates local high alarm onto alert.
//- Mask bit 4, reset zero, gates remote high alarm onto alert.
//- Mask bit 3, reset zero, gates remote low alarm onto alert.
//- Mask bit 1, reset zero, gates critical alarm onto alert.
//- Mask bit 0, reset zero, gates tach alarm onto alert.
//- Flags stay latched until status read; read clears only ceased conditions.
//- Status bit 7 shows conversion busy; never affects alert.
//- Status bit 6 follows local temperature above local high setpoint; raises alert.
//- Comparator mode: alert follows live conditions, not latched flags.
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH
`define ADDR_ALARM_STATUS 8'h02
`define ADDR_ALARM_MASK 8'h16
`define BIT_BUSY 7
`define BIT_LOCAL_HIGH 6
`define BIT_UNUSED_ZERO 5
`define BIT_REMOTE_HIGH 4
`define BIT_REMOTE_LOW 3
`define BIT_DIODE_FAULT 2
`define BIT_CRIT 1
`define BIT_TACH 0
`define MASK_FORCED_ONES 8'hA4
`define MASK_RESET 8'hA4
`define ALERT_SOURCES 8'h5B
`endif

/* File: design/alarm_pkg.sv */
// Types shared by the alarm status and mask logic
package alarm_pkg;
  typedef logic [7:0] reg8_type;
endpackage : alarm_pkg

/* File: design/thermal_alert_status_mask.sv */
// Alarm status latch, alarm mask register and alert output of the thermal sensor
`timescale 1ns/1ps
`include "alarm_defines.svh"
module thermal_alert_status_mask
  import alarm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Live alarm conditions from the measurement blocks
  input wire logic conv_busy,
  input wire logic local_high_cond,
  input wire logic remote_high_cond,
  input wire logic remote_low_cond,
  input wire logic diode_fault_cond,
  input wire logic crit_cond,
  input wire logic tach_cond,
  // Configuration from the config register block
  input wire logic comparator_mode,
  input wire logic pin_is_tach,
  // Register access from the serial interface
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Alert pin, active high, meaningful only when the pin is not a tach input
  output logic alert
);

  reg8_type status_flags;
  reg8_type mask_bits;
  reg8_type live_cond;
  reg8_type status_view;
  reg8_type mask_view;
  reg8_type alert_src;
  logic status_read;

  // Live conditions arranged in status bit order; bit 5 and bit 7 stay out of the latch
  always_comb
  begin
    live_cond = 8'h00;
    live_cond[`BIT_LOCAL_HIGH] = local_high_cond;
    live_cond[`BIT_REMOTE_HIGH] = remote_high_cond;
    live_cond[`BIT_REMOTE_LOW] = remote_low_cond;
    live_cond[`BIT_DIODE_FAULT] = diode_fault_cond;
    live_cond[`BIT_CRIT] = crit_cond;
    live_cond[`BIT_TACH] = tach_cond;
  end

  assign status_read = reg_rd && (reg_addr == `ADDR_ALARM_STATUS);

  // Sticky flags: a live condition always sets, so an event in the read cycle is kept
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_flags <= 8'h00;
    end
    else if (status_read)
    begin
      status_flags <= live_cond;
    end
    else
    begin
      status_flags <= status_flags | live_cond;
    end
  end

  // Mask register; unused bits are hard ones, so writes to them are ignored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_bits <= `MASK_RESET;
    end
    else if (reg_wr && (reg_addr == `ADDR_ALARM_MASK))
    begin
      mask_bits <= reg_wdata | `MASK_FORCED_ONES;
    end
  end

  // Busy is live and unused bit 5 is zero; status has no write path at all
  always_comb
  begin
    status_view = status_flags;
    status_view[`BIT_UNUSED_ZERO] = 1'b0;
    status_view[`BIT_BUSY] = conv_busy;
    mask_view = mask_bits | `MASK_FORCED_ONES;
  end

  // Read data is registered; a status read also clears ceased flags above
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ADDR_ALARM_STATUS: reg_rdata <= status_view;
        `ADDR_ALARM_MASK: reg_rdata <= mask_view;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Comparator mode watches live conditions, latched mode the sticky flags
  always_comb
  begin
    if (comparator_mode)
    begin
      alert_src = live_cond & ~mask_bits & `ALERT_SOURCES;
    end
    else
    begin
      alert_src = status_flags & ~mask_bits & `ALERT_SOURCES;
    end
  end

  // Registered alert; tach alarm cannot reach a pin that is serving as tach input
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert <= 1'b0;
    end
    else
    begin
      alert <= (|alert_src) && !pin_is_tach;
    end
  end

  // Fault flag never drives the alert
  a_fault_no_alert: assert property (@(posedge mclk) disable iff (!rst_n)
    (live_cond == 8'h04 && status_flags == 8'h04) |=> !alert)
    else $error("diode fault raised alert");

  a_status_bit_five: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(reg_rd) && $past(reg_addr) == `ADDR_ALARM_STATUS |-> !reg_rdata[5])
    else $error("status bit 5 read as one");

  a_mask_ones_read: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADDR_ALARM_MASK |=> (reg_rdata & 8'hA4) == 8'hA4)
    else $error("unused mask bits not one");

  a_flag_stays_set: assert property (@(posedge mclk) disable iff (!rst_n)
    remote_high_cond && !status_read |=> status_flags[4])
    else $error("remote high flag not latched");

  a_read_clears_ceased: assert property (@(posedge mclk) disable iff (!rst_n)
    status_read && !crit_cond |=> !status_flags[1])
    else $error("ceased flag survived read");

  a_latch_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    status_flags[3] && !status_read |=> status_flags[3])
    else $error("low flag dropped without read");

  a_masked_local: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && status_flags[6] && !mask_bits[6] && !pin_is_tach |=> alert)
    else $error("unmasked local high gave no alert");

  a_comp_release: assert property (@(posedge mclk) disable iff (!rst_n)
    comparator_mode && live_cond == 8'h00 |=> !alert)
    else $error("comparator alert did not release");

  a_tach_pin_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_is_tach |=> !alert)
    else $error("alert while pin is tach input");

  a_mask_suppress: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && ((status_flags & ~mask_bits & 8'h5B) == 8'h00) |=> !alert)
    else $error("masked flags raised alert");

  // Each live condition reaches its sticky flag one edge later
  a_high_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    remote_high_cond |=> status_flags[`BIT_REMOTE_HIGH])
    else $error("remote high condition not latched");

  // Low alarm latches from the live condition
  a_low_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    remote_low_cond |=> status_flags[`BIT_REMOTE_LOW])
    else $error("remote low condition not latched");

  // Diode fault is still reported in status even though it raises no alert
  a_fault_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    diode_fault_cond |=> status_flags[`BIT_DIODE_FAULT])
    else $error("diode fault not latched");

  // Critical alarm latches from the live condition
  a_crit_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    crit_cond |=> status_flags[`BIT_CRIT])
    else $error("critical condition not latched");

  // Tach alarm latches so a polling host can see it
  a_tach_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    tach_cond |=> status_flags[`BIT_TACH])
    else $error("tach condition not latched");

  // Local high alarm latches from the live condition
  a_local_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    local_high_cond |=> status_flags[`BIT_LOCAL_HIGH])
    else $error("local high condition not latched");

  // A write aimed at status must not disturb the flags
  a_status_read_only: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && !reg_rd && reg_addr == `ADDR_ALARM_STATUS |=>
    status_flags == ($past(status_flags) | $past(live_cond)))
    else $error("write changed status flags");

  // Busy bit is shown live, taken in the read cycle
  a_busy_in_read: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADDR_ALARM_STATUS |=> reg_rdata[`BIT_BUSY] == $past(conv_busy))
    else $error("busy bit not shown in status read");

  // Busy alone must never pull the alert
  a_busy_no_alert: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && conv_busy && ((status_flags & ~mask_bits & 8'h5B) == 8'h00) |=> !alert)
    else $error("busy raised alert");

  // Fault alone in comparator mode keeps the pin quiet too
  a_fault_comp_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    comparator_mode && live_cond == 8'h04 |=> !alert)
    else $error("diode fault raised comparator alert");

  // A mask write lands with the unused bits forced high
  a_mask_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_addr == `ADDR_ALARM_MASK |=> mask_bits == ($past(reg_wdata) | 8'hA4))
    else $error("mask write did not land");

  // Mask only changes on its own write
  a_mask_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr && reg_addr == `ADDR_ALARM_MASK) |=> mask_bits == $past(mask_bits))
    else $error("mask changed without write");

  // Forced bits never drop in the stored mask
  a_mask_ones_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr |=> (mask_bits & 8'hA4) == 8'hA4)
    else $error("stored mask lost a forced one");

  // Unmasked remote high flag drives the alert
  a_mask_remote_high: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && status_flags[4] && !mask_bits[4] && !pin_is_tach |=> alert)
    else $error("unmasked remote high gave no alert");

  // Unmasked remote low flag drives the alert
  a_mask_remote_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && status_flags[3] && !mask_bits[3] && !pin_is_tach |=> alert)
    else $error("unmasked remote low gave no alert");

  // Unmasked critical flag drives the alert
  a_mask_crit_alarm: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && status_flags[1] && !mask_bits[1] && !pin_is_tach |=> alert)
    else $error("unmasked critical gave no alert");

  // Unmasked tach flag drives the alert while the pin is still an alert output
  a_mask_tach_alarm: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && status_flags[0] && !mask_bits[0] && !pin_is_tach |=> alert)
    else $error("unmasked tach gave no alert");

  // Comparator mode asserts from live unmasked conditions
  a_comp_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    comparator_mode && ((live_cond & ~mask_bits & 8'h5B) != 8'h00) && !pin_is_tach |=> alert)
    else $error("comparator alert missing");

  // Comparator mode releases once every unmasked condition is gone
  a_comp_masked: assert property (@(posedge mclk) disable iff (!rst_n)
    comparator_mode && ((live_cond & ~mask_bits & 8'h5B) == 8'h00) |=> !alert)
    else $error("comparator alert stuck");

  // Any unmasked latched source is enough for the alert
  a_alert_any_source: assert property (@(posedge mclk) disable iff (!rst_n)
    !comparator_mode && ((status_flags & ~mask_bits & 8'h5B) != 8'h00) && !pin_is_tach |=> alert)
    else $error("unmasked source gave no alert");

  // Mask read shows the stored bits plus the forced ones
  a_read_returns_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADDR_ALARM_MASK |=> reg_rdata == ($past(mask_bits) | 8'hA4))
    else $error("mask read wrong");

  // Status read returns the flags as they stood before the clear
  a_read_snapshot: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADDR_ALARM_STATUS |=> (reg_rdata & 8'h5F) == ($past(status_flags) & 8'h5F))
    else $error("status read lost a flag");

  // Undecoded addresses read zero
  a_other_addr_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr != `ADDR_ALARM_STATUS && reg_addr != `ADDR_ALARM_MASK |=> reg_rdata == 8'h00)
    else $error("undecoded address read nonzero");

  // Read data stands until the next read
  a_rdata_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == $past(reg_rdata))
    else $error("read data changed without read");

  // A condition still present at the read keeps its flag
  a_read_keeps_live: assert property (@(posedge mclk) disable iff (!rst_n)
    status_read && remote_low_cond |=> status_flags[3])
    else $error("live flag cleared by read");

  // A ceased remote high condition is cleared by the read
  a_read_clears_high: assert property (@(posedge mclk) disable iff (!rst_n)
    status_read && !remote_high_cond |=> !status_flags[4])
    else $error("ceased high flag survived read");

  // Comparator mode also stays quiet while the pin serves as tach input
  a_comp_tach_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    comparator_mode && pin_is_tach |=> !alert)
    else $error("comparator alert on tach pin");

  // A ceased local high condition is cleared by the read
  a_read_clears_local: assert property (@(posedge mclk) disable iff (!rst_n)
    status_read && !local_high_cond |=> !status_flags[6])
    else $error("ceased local flag survived read");

endmodule : thermal_alert_status_mask

/* File: tb/host_model.sv */
// Host model issuing single-byte register reads and writes
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle until the first request
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
  // One-cycle strobe; on release address and data get inverted so stale values never look valid
  task access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {~wr, wr, a, d};
    @(negedge mclk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask : access
endmodule : host_model

/* File: tb/thermal_alert_status_mask_test.sv */
// Self-checking bench for the alarm status and mask logic
`timescale 1ns/1ps
`include "alarm_defines.svh"
module thermal_alert_status_mask_test;
  logic mclk, rst_n, comparator_mode, pin_is_tach, reg_rd, reg_wr, alert;
  logic [7:0] cond, reg_addr, reg_wdata, reg_rdata, q, bm;
  int miscompares, check_count;
  int src[6] = '{6, 4, 3, 2, 1, 0};
  thermal_alert_status_mask dut (.mclk(mclk), .rst_n(rst_n), .conv_busy(cond[7]),
    .local_high_cond(cond[6]), .remote_high_cond(cond[4]), .remote_low_cond(cond[3]),
    .diode_fault_cond(cond[2]), .crit_cond(cond[1]), .tach_cond(cond[0]), .comparator_mode(comparator_mode),
    .pin_is_tach(pin_is_tach), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alert(alert));
  host_model host (.mclk(mclk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // 200 MHz clock
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(0, a, 8'h00, q);
    check(q, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1, a, d, q);
  endtask : wr
  // Short condition pulse, gone well before the flag is read
  task pulse(input int b);
    @(negedge mclk);
    cond[b] = 1;
    repeat (2) @(negedge mclk);
    cond[b] = 0;
    repeat (2) @(negedge mclk);
  endtask : pulse
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #20000;
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    rst_n = 0;
    cond = 0;
    comparator_mode = 0;
    pin_is_tach = 0;
    repeat (4) @(negedge mclk);
    rst_n = 1;
    rd(`ADDR_ALARM_MASK, 8'hA4);
    wr(`ADDR_ALARM_MASK, 8'h00);
    rd(`ADDR_ALARM_MASK, 8'hA4);
    wr(`ADDR_ALARM_STATUS, 8'hFF);
    rd(`ADDR_ALARM_STATUS, 8'h00);
    rd(8'h33, 8'h00);
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 6; i++)
      begin
        bm = 8'h01 << src[i];
        wr(`ADDR_ALARM_MASK, m ? bm : 8'h00);
        rd(`ADDR_ALARM_MASK, m ? (bm | 8'hA4) : 8'hA4);
        pulse(src[i]);
        check(alert, (src[i] != 2 && m == 0));
        rd(`ADDR_ALARM_STATUS, bm);
        rd(`ADDR_ALARM_STATUS, 8'h00);
      end
    wr(`ADDR_ALARM_MASK, 8'h00);
    pin_is_tach = 1;
    pulse(0);
    check(alert, 0);
    rd(`ADDR_ALARM_STATUS, 8'h01);
    pin_is_tach = 0;
    cond[4] = 1;
    rd(`ADDR_ALARM_STATUS, 8'h10);
    cond[4] = 0;
    check(alert, 1);
    rd(`ADDR_ALARM_STATUS, 8'h10);
    rd(`ADDR_ALARM_STATUS, 8'h00);
    cond[7] = 1;
    rd(`ADDR_ALARM_STATUS, 8'h80);
    check(alert, 0);
    cond[7] = 0;
    comparator_mode = 1;
    cond[1] = 1;
    repeat (2) @(negedge mclk);
    check(alert, 1);
    cond[1] = 0;
    repeat (2) @(negedge mclk);
    check(alert, 0);
    rd(`ADDR_ALARM_STATUS, 8'h02);
    complete_run();
  end
endmodule : thermal_alert_status_mask_test
